// ==== verilog/sysbus_cfg_regs.sv ====
// Purpose: System control, bus window control, reset latch and fast irq edge registers
// Assumes: AXI4-Lite slave, one 16-bit register per word, byte address four times the index
// Notes: Outputs are decoded config levels plus a small external-cycle timer
// Summary of operation
// - Byte-high disable set stops driving the byte-high pin.
// - Internal memory enable clear sends internal area accesses externally; loaded from pin.
// - Segmentation enabled saves code segment pointer; disabled saves instruction pointer only.
// - Flash map bit selects segment 0 or segment 1 at 01'0000h.
// - Stack size field selects 256,128,64,32,512 or 1024 words; 101b/110b forbidden.
// - Significant stack pointer bit count follows stack size.
// - Stack tops at FBFEh, or FDFEh for 1024 words with no wrap.
// - Cycle wait field inserts fifteen minus value wait states.
// - Command delay bit clear delays command half clock after latch strobe; the timer waits one full clock.
// - Tristate wait bit clear adds one tristate wait state.
// - Two-bit bus format field selects 8/16-bit, muxed or demuxed bus.
// - Window 0 bus format loaded from port 0 levels at reset end when the access pin is low.
// - Window 0 resets to zero with access pin high, else active and lengthened.
// - Latch lengthen bit gives lengthened address latch strobe for window.
// - Window bus active bit enables external cycles in that window.
// - Ready enable makes ready input end the cycle, else wait field times it.
// - Ready polarity selects which ready level ends the cycle.
// - Select gating bits restrict chip select to the command duration.
// - Write strobe config clear turns write and byte-high pins into low/high strobes.
// - Select line count field enables 3, 2, none or 5 chip selects.
// - Segment line count field enables 4, none, 8 or 2 segment address lines.
// - Clock ratio code sets CPU clock multiplier 2.5,0.5,10,1,5,2,3,4.
// - Clock bits reload only on long reset; other latch bits on any reset.
// - Edge field 00 disables fast irq and power-down pin use.
// - Edge 01 rising, 10 falling, 11 any; levels govern power-down for 01 and 10, edges wake it for 11.
`timescale 1ns/1ps
`include "sysbus_cfg_map.svh"
module sysbus_cfg_regs #(
  parameter int NUM_WIN = 5
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic LONG_RST_I,
  input wire logic EXT_ACCESS_PIN_I,
  input wire logic [7:0] PORT0_HIGH_I,
  input wire logic [1:0] PORT0_BUS_FORMAT_FIELD_I,
  input wire logic FAST_IRQ_INPUT_PIN_I,
  input wire logic CYCLE_REQ_I,
  input wire logic [2:0] CYCLE_WIN_I,
  input wire logic READY_PIN_I,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic BYTE_HIGH_ENABLE_PIN_OE_O,
  output logic INTERNAL_MEMORY_ENABLE_O,
  output logic SAVE_CODE_SEGMENT_O,
  output logic [23:0] FLASH_BASE_O,
  output logic [11:0] STACK_PTR_MASK_O,
  output logic [15:0] STACK_TOP_O,
  output logic STACK_CIRCULAR_O,
  output logic WRITE_LOW_HIGH_STROBES_O,
  output logic [4:0] CHIP_SELECT_EN_O,
  output logic [7:0] SEGMENT_LINE_EN_O,
  output logic [2:0] CPU_CLOCK_RATIO_O,
  output logic [1:0] BUS_FORMAT_O,
  output logic LATCH_STROBE_O,
  output logic LATCH_LONG_O,
  output logic COMMAND_O,
  output logic CHIP_SELECT_O,
  output logic CYCLE_DONE_O,
  output logic FAST_IRQ_EVENT_O,
  output logic POWER_DOWN_ALLOW_O,
  output logic POWER_DOWN_WAKE_O
);
  initial if (NUM_WIN != 5) $error("sysbus_cfg_regs serves exactly five windows");
  // ****************************************************************
  // Pin synchronisers and reset strap capture
  // ****************************************************************
  logic [2:0] ea_s_r, rdy_s_r, irq_s_r;
  logic ea_lvl_r, rdy_lvl_r, irq_lvl_r, irq_prev_r;
  logic rst_d_r;
  always_ff @(posedge SYS_CLK_I) begin
    ea_s_r <= {ea_s_r[1:0], EXT_ACCESS_PIN_I};
    rdy_s_r <= {rdy_s_r[1:0], READY_PIN_I};
    irq_s_r <= {irq_s_r[1:0], FAST_IRQ_INPUT_PIN_I};
    if (ea_s_r[1] == ea_s_r[2]) ea_lvl_r <= ea_s_r[2];
    if (rdy_s_r[1] == rdy_s_r[2]) rdy_lvl_r <= rdy_s_r[2];
    if (irq_s_r[1] == irq_s_r[2]) irq_lvl_r <= irq_s_r[2];
    irq_prev_r <= irq_lvl_r;
    rst_d_r <= RST_I;
  end
  wire rst_release = rst_d_r && !RST_I;
  // ****************************************************************
  // Register bank
  // ****************************************************************
  logic [15:0] win_r [NUM_WIN];
  logic [15:0] win_nxt [NUM_WIN];
  logic [15:0] sys_r, sys_nxt, irq_r, irq_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [15:0] aw_a_r, aw_a_nxt, w_d_r, w_d_nxt;
  logic [1:0] w_s_r, w_s_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] rd_val;
  logic rd_hit, wr_hit;
  wire do_write = aw_got_r && w_got_r && !bvalid_r;
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d, input logic [1:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  always_comb begin
    rd_hit = 1'b1;
    case (S_AXI_ARADDR[17:2])
      `OFS_RESET_CFG: rd_val = {8'h00, cfg_r};
      `OFS_EXT_IRQ: rd_val = irq_r;
      `OFS_WIN0: rd_val = win_r[0];
      `OFS_WIN1: rd_val = win_r[1];
      `OFS_WIN2: rd_val = win_r[2];
      `OFS_WIN3: rd_val = win_r[3];
      `OFS_WIN4: rd_val = win_r[4];
      `OFS_SYSCTL: rd_val = sys_r;
      default: begin
        rd_val = `RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
    if (S_AXI_ARADDR[31:18] != 14'h0000 || S_AXI_ARADDR[1:0] != 2'b00) rd_hit = 1'b0;
  end
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    aw_a_nxt = aw_a_r;
    w_d_nxt = w_d_r;
    w_s_nxt = w_s_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    sys_nxt = sys_r;
    irq_nxt = irq_r;
    cfg_nxt = cfg_r;
    wr_hit = 1'b1;
    for (int i = 0; i < NUM_WIN; i++) win_nxt[i] = win_r[i];
    if (S_AXI_AWVALID && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      aw_a_nxt = (S_AXI_AWADDR[31:18] != 14'h0000 || S_AXI_AWADDR[1:0] != 2'b00) ? 16'h0001 : S_AXI_AWADDR[17:2];
    end
    if (S_AXI_WVALID && !w_got_r) begin
      w_got_nxt = 1'b1;
      w_d_nxt = S_AXI_WDATA[15:0];
      w_s_nxt = S_AXI_WSTRB[1:0];
    end
    if (do_write) begin
      case (aw_a_r)
        `OFS_EXT_IRQ: irq_nxt = merge(irq_r, w_d_r, w_s_r);
        `OFS_WIN0: win_nxt[0] = merge(win_r[0], w_d_r, w_s_r);
        `OFS_WIN1: win_nxt[1] = merge(win_r[1], w_d_r, w_s_r);
        `OFS_WIN2: win_nxt[2] = merge(win_r[2], w_d_r, w_s_r);
        `OFS_WIN3: win_nxt[3] = merge(win_r[3], w_d_r, w_s_r);
        `OFS_WIN4: win_nxt[4] = merge(win_r[4], w_d_r, w_s_r);
        `OFS_SYSCTL: sys_nxt = merge(sys_r, w_d_r, w_s_r);
        `OFS_RESET_CFG: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? 2'b00 : 2'b10;
    end
    if (bvalid_r && S_AXI_BREADY) bvalid_nxt = 1'b0;
    if (S_AXI_ARVALID && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {16'h0000, rd_val};
      rresp_nxt = rd_hit ? 2'b00 : 2'b10;
    end else if (rvalid_r && S_AXI_RREADY) rvalid_nxt = 1'b0;
    if (rst_release) begin
      // Straps are caught just after release, never inside the reset branch
      cfg_nxt[4:0] = PORT0_HIGH_I[4:0];
      if (LONG_RST_I) cfg_nxt[7:5] = PORT0_HIGH_I[7:5];
      sys_nxt[`F_INTERNAL_MEMORY_ENABLE] = !ea_lvl_r;
      if (ea_lvl_r) win_nxt[0] = `RST_ZERO;
      else win_nxt[0] = `WIN0_BUS_DEFAULT | {8'h00, PORT0_BUS_FORMAT_FIELD_I, 6'h00};
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_a_r <= `RST_ZERO;
      w_d_r <= `RST_ZERO;
      w_s_r <= 2'b00;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rvalid_r <= 1'b0;
      rresp_r <= 2'b00;
      rdata_r <= 32'h0000_0000;
      sys_r <= `RST_ZERO;
      irq_r <= `RST_ZERO;
      if (LONG_RST_I) cfg_r <= `RST_CFG;
      else cfg_r[4:0] <= 5'h1f;
      for (int i = 0; i < NUM_WIN; i++) win_r[i] <= `RST_ZERO;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      aw_a_r <= aw_a_nxt;
      w_d_r <= w_d_nxt;
      w_s_r <= w_s_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      sys_r <= sys_nxt;
      irq_r <= irq_nxt;
      cfg_r <= cfg_nxt;
      for (int i = 0; i < NUM_WIN; i++) win_r[i] <= win_nxt[i];
    end
  end
  assign S_AXI_AWREADY = !aw_got_r;
  assign S_AXI_WREADY = !w_got_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  // ****************************************************************
  // Decoded configuration outputs
  // ****************************************************************
  logic [2:0] stk;
  logic [11:0] mask_nxt;
  logic [7:0] seg_nxt;
  logic [4:0] cs_nxt;
  logic edge_hit, pd_allow, pd_wake;
  sysbus_cfg_pkg::edge_mode_t emode;
  always_comb begin
    stk = sys_r[`F_STK_LO +: 3];
    case (stk)
      3'b000: mask_nxt = 12'h1ff;
      3'b001: mask_nxt = 12'h0ff;
      3'b010: mask_nxt = 12'h07f;
      3'b011: mask_nxt = 12'h03f;
      3'b100: mask_nxt = 12'h3ff;
      3'b111: mask_nxt = 12'hfff;
      default: mask_nxt = 12'h1ff; // Forbidden codes fall back to the reset size
    endcase
    case (cfg_r[`F_SELECT_LINE_COUNT_LO +: 2])
      2'b00: cs_nxt = 5'h07;
      2'b01: cs_nxt = 5'h03;
      2'b10: cs_nxt = 5'h00;
      default: cs_nxt = 5'h1f;
    endcase
    case (cfg_r[`F_SEGMENT_LINE_COUNT_LO +: 2])
      2'b00: seg_nxt = 8'h0f;
      2'b01: seg_nxt = 8'h00;
      2'b10: seg_nxt = 8'hff;
      default: seg_nxt = 8'h03;
    endcase
    emode = sysbus_cfg_pkg::edge_mode_t'(irq_r[1:0]);
    edge_hit = (irq_r[0] && irq_lvl_r && !irq_prev_r) || (irq_r[1] && !irq_lvl_r && irq_prev_r);
    pd_allow = !(irq_r[1:0] == 2'b01 && irq_lvl_r) && !(irq_r[1:0] == 2'b10 && !irq_lvl_r);
    pd_wake = (emode == sysbus_cfg_pkg::EDGE_ANY) ? edge_hit : (irq_r[0] ? irq_lvl_r : irq_r[1] && !irq_lvl_r);
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      BYTE_HIGH_ENABLE_PIN_OE_O <= 1'b1;
      INTERNAL_MEMORY_ENABLE_O <= 1'b0;
      SAVE_CODE_SEGMENT_O <= 1'b1;
      FLASH_BASE_O <= 24'h00_0000;
      STACK_PTR_MASK_O <= 12'h1ff;
      STACK_TOP_O <= `STACK_TOP_STD;
      STACK_CIRCULAR_O <= 1'b1;
      WRITE_LOW_HIGH_STROBES_O <= 1'b0;
      CHIP_SELECT_EN_O <= 5'h1f;
      SEGMENT_LINE_EN_O <= 8'h03;
      CPU_CLOCK_RATIO_O <= 3'h7;
      FAST_IRQ_EVENT_O <= 1'b0;
      POWER_DOWN_ALLOW_O <= 1'b1;
      POWER_DOWN_WAKE_O <= 1'b0;
    end else begin
      BYTE_HIGH_ENABLE_PIN_OE_O <= !sys_r[`F_HIGH_BYTE_PIN_DISABLE];
      INTERNAL_MEMORY_ENABLE_O <= sys_r[`F_INTERNAL_MEMORY_ENABLE];
      SAVE_CODE_SEGMENT_O <= !sys_r[`F_SEGMENTATION_DISABLE];
      FLASH_BASE_O <= sys_r[`F_FLASH_SEGMENT_MAP] ? `FLASH_SEG1_BASE : 24'h00_0000;
      STACK_PTR_MASK_O <= mask_nxt;
      STACK_TOP_O <= (stk == 3'b111) ? `STACK_TOP_BIG : `STACK_TOP_STD;
      STACK_CIRCULAR_O <= stk != 3'b111;
      WRITE_LOW_HIGH_STROBES_O <= !cfg_r[`F_WRC];
      CHIP_SELECT_EN_O <= cs_nxt;
      SEGMENT_LINE_EN_O <= seg_nxt;
      CPU_CLOCK_RATIO_O <= cfg_r[`F_CLK_LO +: 3];
      FAST_IRQ_EVENT_O <= edge_hit;
      POWER_DOWN_ALLOW_O <= pd_allow;
      POWER_DOWN_WAKE_O <= pd_wake;
    end
  end
  // ****************************************************************
  // External bus cycle timer
  // ****************************************************************
  sysbus_cfg_pkg::cycle_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [15:0] cw_r, cw_nxt;
  logic cs_gate;
  wire ready_hit = rdy_lvl_r == cw_r[`F_RDYPOL];
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cw_nxt = cw_r;
    case (st_r)
      sysbus_cfg_pkg::CYC_IDLE: begin
        if (CYCLE_REQ_I && CYCLE_WIN_I < 3'(NUM_WIN) && win_r[CYCLE_WIN_I][`F_BUSACT]) begin
          cw_nxt = win_r[CYCLE_WIN_I];
          st_nxt = sysbus_cfg_pkg::CYC_LATCH;
          cnt_nxt = win_r[CYCLE_WIN_I][`F_ALECTL] ? 4'h1 : 4'h0;
        end
      end
      sysbus_cfg_pkg::CYC_LATCH: begin
        if (cnt_r != 4'h0) cnt_nxt = cnt_r - 4'h1;
        else begin
          // One clock stands in for the half-clock command delay
          st_nxt = cw_r[`F_RWDC] ? sysbus_cfg_pkg::CYC_CMD : sysbus_cfg_pkg::CYC_WAIT;
          cnt_nxt = `MAX_WAIT - cw_r[`F_CYCLE_WAIT_COUNT_LO +: 4];
        end
      end
      sysbus_cfg_pkg::CYC_WAIT: st_nxt = sysbus_cfg_pkg::CYC_CMD;
      sysbus_cfg_pkg::CYC_CMD: begin
        if (cw_r[`F_RDYEN]) begin
          if (ready_hit) st_nxt = cw_r[`F_MTTC] ? sysbus_cfg_pkg::CYC_IDLE : sysbus_cfg_pkg::CYC_TRI;
        end else if (cnt_r != 4'h0) cnt_nxt = cnt_r - 4'h1;
        else st_nxt = cw_r[`F_MTTC] ? sysbus_cfg_pkg::CYC_IDLE : sysbus_cfg_pkg::CYC_TRI;
      end
      sysbus_cfg_pkg::CYC_TRI: st_nxt = sysbus_cfg_pkg::CYC_IDLE;
      default: st_nxt = sysbus_cfg_pkg::CYC_IDLE;
    endcase
    cs_gate = cw_nxt[`F_CSREN] || cw_nxt[`F_CSWEN];
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      st_r <= sysbus_cfg_pkg::CYC_IDLE;
      cnt_r <= 4'h0;
      cw_r <= `RST_ZERO;
      BUS_FORMAT_O <= 2'b00;
      LATCH_STROBE_O <= 1'b0;
      LATCH_LONG_O <= 1'b0;
      COMMAND_O <= 1'b0;
      CHIP_SELECT_O <= 1'b0;
      CYCLE_DONE_O <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cw_r <= cw_nxt;
      BUS_FORMAT_O <= cw_nxt[`F_BUS_FORMAT_FIELD_LO +: 2];
      LATCH_STROBE_O <= st_nxt == sysbus_cfg_pkg::CYC_LATCH;
      LATCH_LONG_O <= cw_nxt[`F_ALECTL];
      COMMAND_O <= st_nxt == sysbus_cfg_pkg::CYC_CMD;
      CHIP_SELECT_O <= cs_gate ? st_nxt == sysbus_cfg_pkg::CYC_CMD : st_nxt != sysbus_cfg_pkg::CYC_IDLE;
      CYCLE_DONE_O <= st_r != sysbus_cfg_pkg::CYC_IDLE && st_nxt == sysbus_cfg_pkg::CYC_IDLE;
    end
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence cmd_end_s;
    st_r == sysbus_cfg_pkg::CYC_CMD && !cw_r[`F_RDYEN] && cnt_r == 4'h0;
  endsequence
  stack_top_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    ##1 (STACK_TOP_O == ($past(stk) == 3'b111 ? `STACK_TOP_BIG : `STACK_TOP_STD)))
    else $error("stack top wrong");
  bhe_pin_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    ##1 (BYTE_HIGH_ENABLE_PIN_OE_O == !$past(sys_r[`F_HIGH_BYTE_PIN_DISABLE]))) else $error("byte high pin drive wrong");
  inactive_win_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st_r == sysbus_cfg_pkg::CYC_IDLE && CYCLE_REQ_I && CYCLE_WIN_I < 3'(NUM_WIN) && !win_r[CYCLE_WIN_I][`F_BUSACT]
    |=> st_r == sysbus_cfg_pkg::CYC_IDLE) else $error("cycle started in inactive window");
  wait_count_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st_r == sysbus_cfg_pkg::CYC_LATCH && cnt_r == 4'h0 |=> cnt_r == `MAX_WAIT - cw_r[3:0])
    else $error("wait count not fifteen minus field");
  tristate_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    cmd_end_s |=> (cw_r[`F_MTTC] ? st_r == sysbus_cfg_pkg::CYC_IDLE : st_r == sysbus_cfg_pkg::CYC_TRI))
    else $error("tristate wait wrong");
  ready_end_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st_r == sysbus_cfg_pkg::CYC_CMD && cw_r[`F_RDYEN] && rdy_lvl_r != cw_r[`F_RDYPOL]
    |=> st_r == sysbus_cfg_pkg::CYC_CMD) else $error("cycle ended on inactive ready");
  cs_gating_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (cw_r[`F_CSREN] || cw_r[`F_CSWEN]) && CHIP_SELECT_O |-> COMMAND_O) else $error("gated select outside command");
  no_edge_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    irq_r[1:0] == 2'b00 [*2] |-> !FAST_IRQ_EVENT_O) else $error("irq event while disabled");
  delay_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st_r == sysbus_cfg_pkg::CYC_LATCH && cnt_r == 4'h0 && !cw_r[`F_RWDC] |=> ##1 COMMAND_O)
    else $error("command delay wrong");
endmodule // sysbus_cfg_regs

// ==== verilog/sysbus_cfg_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Offsets are register indices on a 32-bit AXI4-Lite slave; byte address is four times the index
// Notes: Definitions only
`ifndef SYSBUS_CFG_MAP_SVH
`define SYSBUS_CFG_MAP_SVH
// ****************************************************************
// Register indices (all are even; each word sits at four times its index)
// ****************************************************************
`define OFS_RESET_CFG 16'hf108
`define OFS_EXT_IRQ 16'hf1c0
`define OFS_WIN0 16'hff0c
`define OFS_WIN1 16'hff14
`define OFS_WIN2 16'hff16
`define OFS_WIN3 16'hff18
`define OFS_WIN4 16'hff1a
`define OFS_SYSCTL 16'hff40
`define WIN_STEP 16'h0002
// ****************************************************************
// Field positions
// ****************************************************************
`define F_CYCLE_WAIT_COUNT_LO 0
`define F_RWDC 4
`define F_MTTC 5
`define F_BUS_FORMAT_FIELD_LO 6
`define F_ALECTL 9
`define F_BUSACT 10
`define F_RDYEN 12
`define F_RDYPOL 13
`define F_CSREN 14
`define F_CSWEN 15
`define F_HIGH_BYTE_PIN_DISABLE 9
`define F_INTERNAL_MEMORY_ENABLE 10
`define F_SEGMENTATION_DISABLE 11
`define F_FLASH_SEGMENT_MAP 12
`define F_STK_LO 13
`define F_WRC 0
`define F_SELECT_LINE_COUNT_LO 1
`define F_SEGMENT_LINE_COUNT_LO 3
`define F_CLK_LO 5
// ****************************************************************
// Reset values and counts
// ****************************************************************
`define RST_ZERO 16'h0000
`define RST_CFG 8'hff
`define WIN0_BUS_DEFAULT 16'h0600
`define STACK_TOP_STD 16'hfbfe
`define STACK_TOP_BIG 16'hfdfe
`define FLASH_SEG1_BASE 24'h01_0000
`define MAX_WAIT 4'hf
`endif

// ==== verilog/sysbus_cfg_pkg.sv ====
// Purpose: Types for the system and bus configuration bank
// Assumes: Nothing
// Notes: Constants live in the map header
package sysbus_cfg_pkg;
  typedef enum logic [1:0] {BT_8_DEMUX, BT_8_MUX, BT_16_DEMUX, BT_16_MUX} bus_format_t;
  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_ANY} edge_mode_t;
  typedef enum {CYC_IDLE, CYC_LATCH, CYC_WAIT, CYC_CMD, CYC_TRI} cycle_state_t;
endpackage

// ==== verification/ext_mem_model.sv ====
// Purpose: External device that ends bus cycles on the ready pin
// Assumes: Command high marks the access
// Notes: Outside an answer it drives the inverse of the active level
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic clk_i,
  input wire logic cmd_i,
  input wire logic pol_i,
  input wire logic [3:0] dly_i,
  output logic rdy_o
);
  logic [3:0] cnt_r = 4'h0;
  // Active level only after dly_i command cycles, a slow device
  always_ff @(posedge clk_i) begin
    cnt_r <= cmd_i ? cnt_r + {3'h0, cnt_r != 4'hf} : 4'h0;
    rdy_o <= (cmd_i && cnt_r >= dly_i) ? pol_i : !pol_i;
  end
endmodule // ext_mem_model

// ==== verification/test_system_bus_config_regs.sv ====
// Purpose: Register, strap and bus cycle checks
// Assumes: Offsets are register indices; the byte address is four times the index
// Notes: Decoded outputs lag writes by one cycle
`timescale 1ns/1ps
`include "sysbus_cfg_map.svh"
module test_system_bus_config_regs;
  logic clk = 0, rst = 1, lng = 1, ea = 1, irq = 0, req = 0, pol = 0, rdy;
  logic [7:0] p0 = 8'hff;
  logic [1:0] bt = 2'h2, fmt, bresp, rresp;
  logic [2:0] win = 3'h0, ratio;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, oe, imem, savecs, circ, strb, lat, cmd, cs, done, ev;
  logic [23:0] fbase;
  logic [11:0] mask;
  logic [15:0] stop;
  logic [4:0] csen;
  logic [7:0] segen;
  logic [3:0] wstrb = 4'hf;
  logic latl, pda, pdw;
  int failures = 0, tests_run = 0, cycles = 0, evn = 0;
  sysbus_cfg_regs u_dut (.SYS_CLK_I(clk), .RST_I(rst), .LONG_RST_I(lng), .EXT_ACCESS_PIN_I(ea),
    .PORT0_HIGH_I(p0), .PORT0_BUS_FORMAT_FIELD_I(bt), .FAST_IRQ_INPUT_PIN_I(irq), .CYCLE_REQ_I(req), .CYCLE_WIN_I(win),
    .READY_PIN_I(rdy), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .BYTE_HIGH_ENABLE_PIN_OE_O(oe),
    .INTERNAL_MEMORY_ENABLE_O(imem), .SAVE_CODE_SEGMENT_O(savecs), .FLASH_BASE_O(fbase),
    .STACK_PTR_MASK_O(mask), .STACK_TOP_O(stop), .STACK_CIRCULAR_O(circ), .WRITE_LOW_HIGH_STROBES_O(strb),
    .CHIP_SELECT_EN_O(csen), .SEGMENT_LINE_EN_O(segen), .CPU_CLOCK_RATIO_O(ratio), .BUS_FORMAT_O(fmt),
    .LATCH_STROBE_O(lat), .LATCH_LONG_O(latl), .COMMAND_O(cmd), .CHIP_SELECT_O(cs), .CYCLE_DONE_O(done),
    .FAST_IRQ_EVENT_O(ev), .POWER_DOWN_ALLOW_O(pda), .POWER_DOWN_WAKE_O(pdw));
  ext_mem_model u_mem (.clk_i(clk), .cmd_i(cmd), .pol_i(pol), .dly_i(4'h6), .rdy_o(rdy));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (ev === 1'b1) evn++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    awaddr <= {14'h0000, a, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, 32'h0000_0000);
    bready <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= {14'h0000, a, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {16'h0000, exp});
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic cyc(input logic [2:0] w, output int nl, output int nc, output int ns, output int nt,
    output logic [1:0] f);
    nl = 0;
    nc = 0;
    ns = 0;
    nt = 0;
    @(posedge clk);
    win <= w;
    req <= 1'b1;
    for (int k = 0; k < 60 && done !== 1'b1; k++) begin
      @(posedge clk);
      if (lat === 1'b1 && nl == 0) f = fmt;
      if (lat === 1'b1) req <= 1'b0;
      nl += int'(lat === 1'b1);
      nc += int'(cmd === 1'b1);
      ns += int'(cs === 1'b1);
      nt += int'(nl > 0 && done !== 1'b1);
    end
    req <= 1'b0;
  endtask
  task automatic rs(input logic e, input logic l, input logic [7:0] p);
    @(posedge clk);
    rst <= 1'b1;
    ea <= e;
    lng <= l;
    p0 <= p;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic dec(input logic [4:0] c, input logic [7:0] s, input logic [2:0] r, input logic w);
    chk({27'h0, csen}, {27'h0, c});
    chk({24'h0, segen}, {24'h0, s});
    chk({29'h0, ratio}, {29'h0, r});
    chk({31'h0, strb}, {31'h0, w});
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    int nl, nc, ns, nt, e0;
    logic [1:0] f;
    logic [2:0] sz [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [11:0] mk [6] = '{12'h1ff, 12'h0ff, 12'h07f, 12'h03f, 12'h3ff, 12'hfff};
    logic [15:0] cv [3] = '{16'h04ff, 16'h464d, 16'h0430};
    int el [3] = '{1, 2, 1}, ec [3] = '{1, 3, 16}, et [3] = '{2, 7, 17}, ef [3] = '{3, 1, 0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(`OFS_RESET_CFG, 16'h00ff, 2'h0);
    rd(`OFS_EXT_IRQ, 16'h0000, 2'h0);
    dec(5'h1f, 8'h03, 3'h7, 1'b0);
    wr(`OFS_RESET_CFG, 16'h0000);
    rd(`OFS_RESET_CFG, 16'h00ff, 2'h0);
    rd(16'h0000, 16'h0000, 2'h2);
    wstrb <= 4'h1;
    wr(`OFS_WIN4, 16'hffff);
    wstrb <= 4'hf;
    rd(`OFS_WIN4, 16'h00ff, 2'h0);
    foreach (sz[i]) begin
      wr(`OFS_SYSCTL, {sz[i], (i % 2) ? 13'h1e00 : 13'h0000});
      rd(`OFS_SYSCTL, {sz[i], (i % 2) ? 13'h1e00 : 13'h0000}, 2'h0);
      chk({20'h0, mask}, {20'h0, mk[i]});
      chk({stop, 15'h0, circ}, {(i == 5) ? 16'hfdfe : 16'hfbfe, 15'h0, i != 5});
      chk({8'h0, fbase}, (i % 2) ? 32'h0001_0000 : 32'h0000_0000);
      chk({29'h0, oe, savecs, imem}, (i % 2) ? 32'h0000_0001 : 32'h0000_0006);
    end
    foreach (cv[i]) begin
      wr(`OFS_WIN1, cv[i]);
      cyc(3'h1, nl, nc, ns, nt, f);
      chk(nl, el[i]);
      chk(nc, ec[i]);
      chk(nt, et[i]);
      chk({31'h0, latl}, {31'h0, cv[i][9]});
      chk({30'h0, f}, ef[i]);
      if (i == 1) chk(ns, nc);
    end
    wr(`OFS_WIN2, 16'h003f);
    cyc(3'h2, nl, nc, ns, nt, f);
    chk(nl, 0);
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      wr(`OFS_WIN3, p[0] ? 16'h343f : 16'h143f);
      cyc(3'h3, nl, nc, ns, nt, f);
      chk({nl > 0, nc >= 6, nc < 20}, 3'h7);
    end
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_EXT_IRQ, m[15:0]);
      repeat (6) @(negedge clk);
      e0 = evn;
      @(posedge clk) irq <= 1'b1;
      repeat (8) @(negedge clk);
      chk(evn - e0, m % 2);
      chk({30'h0, pda, pdw}, (m == 1) ? 32'h0000_0001 : 32'h0000_0002);
      e0 = evn;
      @(posedge clk) irq <= 1'b0;
      repeat (8) @(negedge clk);
      chk(evn - e0, m / 2);
      chk({30'h0, pda, pdw}, (m == 2) ? 32'h0000_0001 : 32'h0000_0002);
    end
    rs(1'b0, 1'b0, 8'h00);
    rd(`OFS_WIN0, 16'h0680, 2'h0);
    rd(`OFS_WIN1, 16'h0000, 2'h0);
    rd(`OFS_RESET_CFG, 16'h00e0, 2'h0);
    dec(5'h07, 8'h0f, 3'h7, 1'b1);
    rs(1'b1, 1'b1, 8'h5a);
    rd(`OFS_WIN0, 16'h0000, 2'h0);
    rd(`OFS_RESET_CFG, 16'h005a, 2'h0);
    dec(5'h03, 8'h03, 3'h2, 1'b1);
    end_sim();
  end
endmodule // test_system_bus_config_regs
